// file: hw/srps_ctrl.sv
// Controller end: refresh scheduling and power-state requests on the command and clock-enable pins.
`include "srps_cfg.svh"

module srps_ctrl #(
    parameter int unsigned REF_CYC = `SRPS_REF_CYC,
    parameter int unsigned ROWS = `SRPS_ROWS,
    parameter bit REF_BURST = 1'b0,
    parameter int unsigned RFC_CYC = `SRPS_RFC_CYC,
    parameter int unsigned RP_CYC = `SRPS_RP_CYC,
    parameter int unsigned RAS_CYC = `SRPS_RAS_CYC,
    parameter int unsigned XSR_CYC = `SRPS_XSR_CYC,
    parameter int unsigned BURST_LEN = `SRPS_BURST_LEN
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Row and burst requests
    input wire logic i_open_row,
    input wire logic i_close_row,
    input wire logic i_read,
    input wire logic i_suspend,
    // Low-power requests and initialization done
    input wire logic i_pd_req,
    input wire logic i_sr_req,
    input wire logic i_deep_req,
    input wire logic i_init_done,
    // Status
    output srps_pkg::srps_cst_e o_state,
    output logic [13:0] o_pend,
    output logic o_row_open,
    // Memory pins
    srps_if.ctrl bus
);

    localparam int unsigned REFI = REF_CYC / ROWS;

    // ---------------------------------------------------------------
    // Registers and next values
    // ---------------------------------------------------------------
    srps_pkg::srps_cst_e st_ff;
    srps_pkg::srps_cst_e nxt_st;
    logic [3:0] pins_ff;
    logic [3:0] nxt_pins;
    logic cke_ff;
    logic nxt_cke;
    logic cke_d_ff;
    logic [15:0] wait_ff;
    logic [15:0] nxt_wait;
    logic row_open_ff;
    logic nxt_row;
    logic [7:0] burst_ff;
    logic [23:0] refi_ff;
    logic [23:0] refresh_period_ff;
    logic [13:0] pend_ff;
    logic [13:0] add;
    logic burst_on;
    logic can_ref;
    logic idle_ok;
    logic ref_fire;
    logic rd_fire;
    logic sched_hold;

    assign burst_on = burst_ff != 8'h00;
    assign can_ref = (pend_ff != 14'h0000) && !burst_on;
    assign idle_ok = !burst_on && !row_open_ff;

    // ---------------------------------------------------------------
    // Command sequencer
    // ---------------------------------------------------------------
    // Priority in idle: due refresh, deep power-down, self refresh, power-down,
    // then row and burst requests. Refresh first keeps the deadline safe.
    always_comb begin
        nxt_st = st_ff;
        nxt_pins = `SRPS_PIN_NOP;
        nxt_cke = 1'b1;
        nxt_wait = (wait_ff != 16'h0000) ? wait_ff - 16'h0001 : wait_ff;
        nxt_row = row_open_ff;
        ref_fire = 1'b0;
        rd_fire = 1'b0;
        case (st_ff)
            srps_pkg::CS_IDLE: begin
                // Suspend is dropped once a refresh falls due.
                nxt_cke = !(i_suspend && burst_on && pend_ff == 14'h0000);
                if (can_ref && row_open_ff) begin
                    nxt_pins = `SRPS_PIN_PRE;
                    nxt_row = 1'b0;
                    nxt_wait = 16'(RP_CYC - 1);
                    nxt_st = srps_pkg::CS_PRE;
                end else if (can_ref) begin
                    nxt_pins = `SRPS_PIN_REF;
                    ref_fire = 1'b1;
                    nxt_wait = 16'(RFC_CYC - 1);
                    nxt_st = srps_pkg::CS_REF;
                end else if (i_deep_req && idle_ok) begin
                    nxt_pins = `SRPS_PIN_BST;
                    nxt_cke = 1'b0;
                    nxt_st = srps_pkg::CS_DEEP;
                end else if (i_sr_req && idle_ok) begin
                    nxt_pins = `SRPS_PIN_REF;
                    nxt_cke = 1'b0;
                    nxt_wait = 16'(RAS_CYC - 1);
                    nxt_st = srps_pkg::CS_SR;
                end else if (i_pd_req && !burst_on) begin
                    nxt_cke = 1'b0;
                    nxt_st = srps_pkg::CS_PD;
                end else if (i_read && row_open_ff && !burst_on) begin
                    nxt_pins = `SRPS_PIN_RD;
                    rd_fire = 1'b1;
                end else if (i_open_row && !row_open_ff) begin
                    nxt_pins = `SRPS_PIN_ACT;
                    nxt_row = 1'b1;
                end else if (i_close_row && row_open_ff && !burst_on) begin
                    nxt_pins = `SRPS_PIN_PRE;
                    nxt_row = 1'b0;
                    nxt_wait = 16'(RP_CYC - 1);
                    nxt_st = srps_pkg::CS_PRE;
                end
            end
            srps_pkg::CS_PRE: begin
                // Recovery after precharge; a refresh waiting on it goes out next.
                if (wait_ff == 16'h0000) begin
                    if (pend_ff != 14'h0000) begin
                        nxt_pins = `SRPS_PIN_REF;
                        ref_fire = 1'b1;
                        nxt_wait = 16'(RFC_CYC - 1);
                        nxt_st = srps_pkg::CS_REF;
                    end else begin
                        nxt_st = srps_pkg::CS_IDLE;
                    end
                end
            end
            srps_pkg::CS_REF: begin
                if (wait_ff == 16'h0000) begin
                    nxt_st = srps_pkg::CS_IDLE;
                end
            end
            srps_pkg::CS_PD: begin
                nxt_cke = 1'b0;
                if (!i_pd_req || pend_ff != 14'h0000) begin
                    nxt_cke = 1'b1;
                    nxt_st = srps_pkg::CS_IDLE;
                end
            end
            srps_pkg::CS_SR: begin
                nxt_cke = 1'b0;
                if (wait_ff == 16'h0000 && !i_sr_req) begin
                    // The one clock runs throughout, so it is stable before enable rises.
                    nxt_cke = 1'b1;
                    nxt_wait = 16'(XSR_CYC - 1);
                    nxt_st = srps_pkg::CS_XSR;
                end
            end
            srps_pkg::CS_XSR: begin
                if (wait_ff == 16'h0000) begin
                    nxt_st = srps_pkg::CS_IDLE;
                end
            end
            srps_pkg::CS_DEEP: begin
                nxt_cke = 1'b0;
                if (!i_deep_req) begin
                    nxt_cke = 1'b1;
                    nxt_st = srps_pkg::CS_INIT;
                end
            end
            srps_pkg::CS_INIT: begin
                // The mode load closes the external initialization sequence.
                if (i_init_done) begin
                    nxt_pins = `SRPS_PIN_LMR;
                    nxt_st = srps_pkg::CS_IDLE;
                end
            end
            default: nxt_st = srps_pkg::CS_IDLE;
        endcase
    end

    // Pin and state registers; the pins come straight from flip-flops.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= srps_pkg::CS_IDLE;
            pins_ff <= `SRPS_PIN_NOP;
            cke_ff <= 1'b1;
            cke_d_ff <= 1'b1;
            wait_ff <= 16'h0000;
            row_open_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            pins_ff <= nxt_pins;
            cke_ff <= nxt_cke;
            cke_d_ff <= cke_ff;
            wait_ff <= nxt_wait;
            row_open_ff <= nxt_row;
        end
    end

    // ---------------------------------------------------------------
    // Burst tracking
    // ---------------------------------------------------------------
    // Mirrors the memory: an edge after a sampled low enable does not count.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            burst_ff <= 8'h00;
        end else if (rd_fire) begin
            burst_ff <= 8'(BURST_LEN + 1);
        end else if (burst_on && cke_d_ff) begin
            burst_ff <= burst_ff - 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // Refresh scheduler
    // ---------------------------------------------------------------
    // Held while the memory refreshes itself or is off; it restarts a full interval
    // (REFI, or REF_CYC in burst mode) on leaving, since both refresh kinds share one row counter.
    assign sched_hold = (st_ff == srps_pkg::CS_SR) || (st_ff == srps_pkg::CS_XSR) ||
                        (st_ff == srps_pkg::CS_DEEP) || (st_ff == srps_pkg::CS_INIT);

    always_comb begin
        add = 14'h0000;
        if (REF_BURST && refresh_period_ff == 24'h000000) begin
            add = 14'(ROWS);
        end else if (!REF_BURST && refi_ff == 24'h000000) begin
            add = 14'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            refi_ff <= 24'h000000;
            refresh_period_ff <= 24'h000000;
            pend_ff <= 14'h0000;
        end else if (sched_hold) begin
            refi_ff <= 24'(REFI - 1);
            refresh_period_ff <= 24'(REF_CYC - 1);
            pend_ff <= 14'h0000;
        end else begin
            refi_ff <= (refi_ff == 24'h000000) ? 24'(REFI - 1) : refi_ff - 24'h000001;
            refresh_period_ff <= (refresh_period_ff == 24'h000000) ? 24'(REF_CYC - 1) : refresh_period_ff - 24'h000001;
            // A new due refresh in the same cycle as an issue is not lost.
            pend_ff <= pend_ff + add - {13'h0000, ref_fire};
        end
    end

    assign bus.cke = cke_ff;
    assign bus.cs_n = pins_ff[3];
    assign bus.ras_n = pins_ff[2];
    assign bus.cas_n = pins_ff[1];
    assign bus.we_n = pins_ff[0];
    assign o_state = st_ff;
    assign o_pend = pend_ff;
    assign o_row_open = row_open_ff;

endmodule : srps_ctrl

// file: hw/srps_cfg.svh
// Timing figures, pin patterns and sizes shared by both ends of the refresh and power link.
`ifndef SRPS_CFG_SVH
`define SRPS_CFG_SVH

// ---------------------------------------------------------------
// Clock and times in their own units
// ---------------------------------------------------------------
`define SRPS_CLK_MHZ 250
`define SRPS_T_REF_MS 64
`define SRPS_T_RFC_NS 80
`define SRPS_T_XSR_NS 120
`define SRPS_T_RAS_NS 42
`define SRPS_T_RP_NS 18
`define SRPS_T_SR_INT_NS 15625
`define SRPS_ROWS 4096
`define SRPS_BURST_LEN 4
`define SRPS_XSR_MIN_CLK 2

// ---------------------------------------------------------------
// Cycle counts derived from the times
// ---------------------------------------------------------------
`define SRPS_CYC_MIN(ns) ((((ns) * `SRPS_CLK_MHZ) + 999) / 1000)
`define SRPS_CYC_MAX(ns) ((((ns) * `SRPS_CLK_MHZ) / 1000) < 1 ? 1 : (((ns) * `SRPS_CLK_MHZ) / 1000))
`define SRPS_REF_CYC (`SRPS_T_REF_MS * 1000 * `SRPS_CLK_MHZ)
`define SRPS_RFC_CYC `SRPS_CYC_MIN(`SRPS_T_RFC_NS)
`define SRPS_RAS_CYC `SRPS_CYC_MIN(`SRPS_T_RAS_NS)
`define SRPS_RP_CYC `SRPS_CYC_MIN(`SRPS_T_RP_NS)
`define SRPS_XSR_CYC (`SRPS_CYC_MIN(`SRPS_T_XSR_NS) < `SRPS_XSR_MIN_CLK ? `SRPS_XSR_MIN_CLK : `SRPS_CYC_MIN(`SRPS_T_XSR_NS))
`define SRPS_SR_INT_CYC `SRPS_CYC_MAX(`SRPS_T_SR_INT_NS)

// ---------------------------------------------------------------
// Command pins {cs_n, ras_n, cas_n, we_n}
// ---------------------------------------------------------------
`define SRPS_PIN_INH 4'hf
`define SRPS_PIN_NOP 4'h7
`define SRPS_PIN_ACT 4'h3
`define SRPS_PIN_RD 4'h5
`define SRPS_PIN_WR 4'h4
`define SRPS_PIN_PRE 4'h2
`define SRPS_PIN_REF 4'h1
`define SRPS_PIN_BST 4'h6
`define SRPS_PIN_LMR 4'h0

`endif

// file: hw/srps_pkg.sv
// Types and the command decoder shared by both ends.
`include "srps_cfg.svh"

package srps_pkg;

    // ---------------------------------------------------------------
    // Commands, device states and controller states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {CMD_INH, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
                              CMD_REF, CMD_BST, CMD_LMR} srps_cmd_e;

    typedef enum logic [2:0] {DS_RUN, DS_SUSP, DS_PPD, DS_APD, DS_SELF, DS_DEEP,
                              DS_UNINIT} srps_dst_e;

    typedef enum logic [2:0] {CS_IDLE, CS_PRE, CS_REF, CS_PD, CS_SR, CS_XSR, CS_DEEP,
                              CS_INIT} srps_cst_e;

    // Turns the four command pins into a command; a high select is always an inhibit.
    function automatic srps_cmd_e srps_decode(input logic [3:0] pins);
        srps_cmd_e c;
        case (pins)
            `SRPS_PIN_NOP: c = CMD_NOP;
            `SRPS_PIN_ACT: c = CMD_ACT;
            `SRPS_PIN_RD: c = CMD_RD;
            `SRPS_PIN_WR: c = CMD_WR;
            `SRPS_PIN_PRE: c = CMD_PRE;
            `SRPS_PIN_REF: c = CMD_REF;
            `SRPS_PIN_BST: c = CMD_BST;
            `SRPS_PIN_LMR: c = CMD_LMR;
            default: c = CMD_INH;
        endcase
        return c;
    endfunction : srps_decode

endpackage : srps_pkg

// file: hw/srps_if.sv
// Command and clock-enable pins between the memory controller and the memory.
interface srps_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;

    modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n);
    modport dram (input cke, input cs_n, input ras_n, input cas_n, input we_n);
endinterface : srps_if

// file: hw/srps_dram.sv
// Memory end: refresh counter, self refresh, power-down, deep power-down and clock suspend.
`include "srps_cfg.svh"

module srps_dram #(
    parameter int unsigned ROWS = `SRPS_ROWS,
    parameter int unsigned BURST_LEN = `SRPS_BURST_LEN,
    parameter int unsigned SR_INT_CYC = `SRPS_SR_INT_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Command pins
    srps_if.dram bus,
    // Status
    output srps_pkg::srps_dst_e o_state,
    output logic [$clog2(ROWS)-1:0] o_row_ctr,
    output logic o_refresh,
    output logic o_buf_en,
    output logic [7:0] o_burst_left,
    output logic o_data_lost
);

    localparam int RW = $clog2(ROWS);

    // ---------------------------------------------------------------
    // Registers and decode
    // ---------------------------------------------------------------
    srps_pkg::srps_dst_e st_ff;
    srps_pkg::srps_cmd_e cmd;
    logic cke_smp_ff;
    logic row_open_ff;
    logic [7:0] burst_ff;
    logic [RW-1:0] row_ctr_ff;
    logic [15:0] srt_ff;
    logic refresh_ff;
    logic buf_en_ff;
    logic lost_ff;
    logic exec;
    logic idle_nop;
    logic sr_tick;

    // Commands run only at an active edge with clock enable high.
    assign cmd = srps_pkg::srps_decode({bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n});
    assign exec = (st_ff == srps_pkg::DS_RUN) && bus.cke;
    assign idle_nop = (cmd == srps_pkg::CMD_NOP) || (cmd == srps_pkg::CMD_INH);
    assign sr_tick = (st_ff == srps_pkg::DS_SELF) && (srt_ff == 16'(SR_INT_CYC - 1));

    // Remembers the clock enable of the previous edge; a low one holds the burst counter at this edge.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cke_smp_ff <= 1'b1;
        end else begin
            cke_smp_ff <= bus.cke;
        end
    end

    // ---------------------------------------------------------------
    // Power state machine
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_ff <= srps_pkg::DS_RUN;
            buf_en_ff <= 1'b1;
        end else begin
            case (st_ff)
                srps_pkg::DS_RUN: begin
                    if (!bus.cke && burst_ff != 8'h00) begin
                        st_ff <= srps_pkg::DS_SUSP;
                    end else if (!bus.cke && cmd == srps_pkg::CMD_REF && !row_open_ff) begin
                        st_ff <= srps_pkg::DS_SELF;
                        buf_en_ff <= 1'b0;
                    end else if (!bus.cke && cmd == srps_pkg::CMD_BST && !row_open_ff) begin
                        st_ff <= srps_pkg::DS_DEEP;
                        buf_en_ff <= 1'b0;
                    end else if (!bus.cke && idle_nop) begin
                        // Open row picks the active variant, else precharge variant.
                        st_ff <= row_open_ff ? srps_pkg::DS_APD : srps_pkg::DS_PPD;
                        buf_en_ff <= 1'b0;
                    end
                end
                srps_pkg::DS_SUSP: begin
                    if (bus.cke) begin
                        st_ff <= srps_pkg::DS_RUN;
                    end
                end
                srps_pkg::DS_PPD, srps_pkg::DS_APD: begin
                    if (bus.cke && idle_nop) begin
                        st_ff <= srps_pkg::DS_RUN;
                        buf_en_ff <= 1'b1;
                    end
                end
                srps_pkg::DS_SELF: begin
                    // Only clock enable is looked at here; pins are ignored.
                    if (bus.cke) begin
                        st_ff <= srps_pkg::DS_RUN;
                        buf_en_ff <= 1'b1;
                    end
                end
                srps_pkg::DS_DEEP: begin
                    if (bus.cke) begin
                        st_ff <= srps_pkg::DS_UNINIT;
                        buf_en_ff <= 1'b1;
                    end
                end
                srps_pkg::DS_UNINIT: begin
                    if (bus.cke && cmd == srps_pkg::CMD_LMR) begin
                        st_ff <= srps_pkg::DS_RUN;
                    end
                end
                default: st_ff <= srps_pkg::DS_RUN;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Row and burst tracking
    // ---------------------------------------------------------------
    // The burst counter holds at every edge that follows a low clock enable.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            row_open_ff <= 1'b0;
            burst_ff <= 8'h00;
        end else begin
            if (exec && cmd == srps_pkg::CMD_ACT) begin
                row_open_ff <= 1'b1;
            end else if (exec && cmd == srps_pkg::CMD_PRE) begin
                row_open_ff <= 1'b0;
            end
            if (exec && (cmd == srps_pkg::CMD_RD || cmd == srps_pkg::CMD_WR)) begin
                burst_ff <= 8'(BURST_LEN);
            end else if (burst_ff != 8'h00 && cke_smp_ff) begin
                burst_ff <= burst_ff - 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Refresh row counter, shared by auto and self refresh
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            row_ctr_ff <= '0;
            srt_ff <= 16'h0000;
            refresh_ff <= 1'b0;
        end else begin
            srt_ff <= (st_ff != srps_pkg::DS_SELF || sr_tick) ? 16'h0000 : srt_ff + 16'h0001;
            refresh_ff <= (exec && cmd == srps_pkg::CMD_REF) || sr_tick;
            if ((exec && cmd == srps_pkg::CMD_REF) || sr_tick) begin
                row_ctr_ff <= row_ctr_ff + RW'(1);
            end
        end
    end

    // Contents are gone once the array is powered off; a mode load after wake clears it.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lost_ff <= 1'b0;
        end else if (st_ff == srps_pkg::DS_DEEP) begin
            lost_ff <= 1'b1;
        end else if (st_ff == srps_pkg::DS_UNINIT && bus.cke && cmd == srps_pkg::CMD_LMR) begin
            lost_ff <= 1'b0;
        end
    end

    assign o_state = st_ff;
    assign o_row_ctr = row_ctr_ff;
    assign o_refresh = refresh_ff;
    assign o_buf_en = buf_en_ff;
    assign o_burst_left = burst_ff;
    assign o_data_lost = lost_ff;

endmodule : srps_dram

// file: verif/srps_monitor.sv
// Checker for refresh and power-state timing on the link pins.
`include "srps_cfg.svh"
module srps_monitor (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Link pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [3:0] pins = {cs_n, ras_n, cas_n, we_n};
    wire logic quiet = cs_n || pins == `SRPS_PIN_NOP;
    logic open_ff, sr_ff;
    logic [7:0] ref_ff, pre_ff, sr_n_ff, xit_ff;
    // Event timers saturate, so a stale event never looks fresh.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {open_ff, sr_ff} <= 2'b00;
            {ref_ff, pre_ff, sr_n_ff, xit_ff} <= 32'hffffffff;
        end else begin
            ref_ff <= pins == `SRPS_PIN_REF && cke ? 8'h01 : ref_ff + 8'(ref_ff != 8'hff);
            pre_ff <= pins == `SRPS_PIN_PRE ? 8'h01 : pre_ff + 8'(pre_ff != 8'hff);
            sr_n_ff <= pins == `SRPS_PIN_REF && !sr_ff ? 8'h01 : sr_n_ff + 8'(sr_n_ff != 8'hff);
            xit_ff <= sr_ff && cke ? 8'h01 : xit_ff + 8'(xit_ff != 8'hff);
            open_ff <= pins == `SRPS_PIN_ACT || (open_ff && pins != `SRPS_PIN_PRE);
            sr_ff <= pins == `SRPS_PIN_REF && !cke || sr_ff && !cke;
        end
    end
    // One domain, so clock and reset are given once for all checks.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ref_quiet_a: assert property (ref_ff < `SRPS_RFC_CYC |-> quiet) else $error("refresh busy");
    ref_ready_a: assert property (
        pins == `SRPS_PIN_REF |-> !open_ff && pre_ff >= `SRPS_RP_CYC)
        else $error("refresh too early");
    sr_stay_a: assert property (sr_ff && sr_n_ff < `SRPS_RAS_CYC |-> !cke) else $error("sr short");
    sr_exit_a: assert property (sr_ff && cke || xit_ff < `SRPS_XSR_CYC |-> quiet)
        else $error("sr exit busy");
    deep_hold_a: assert property ($fell(cke) && pins == `SRPS_PIN_BST |=> !cke [*2])
        else $error("deep enable");
    deep_idle_a: assert property (pins == `SRPS_PIN_BST && !cke |-> !open_ff) else $error("dp row");
    pd_enter_a: assert property (
        $fell(cke) |-> quiet || pins inside {`SRPS_PIN_REF, `SRPS_PIN_BST})
        else $error("pd entry");
    pd_exit_a: assert property ($rose(cke) |-> quiet) else $error("pd exit");
    cover property (pins == `SRPS_PIN_REF && cke);
    cover property (sr_ff && cke);
    cover property ($fell(cke) && pins == `SRPS_PIN_BST);
endmodule : srps_monitor

// file: verif/test_sdram_refresh_power_states.sv
// Bench joining both ends of the refresh and power link.
module test_sdram_refresh_power_states;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_resetn = 1'b0;
    logic [7:0] req = 8'h00; // Init, deep, self, pd, suspend, read, close, open.
    logic row_open, refresh, buf_en, data_lost;
    logic [7:0] burst_left, held;
    logic [3:0] row_ctr;
    logic [13:0] pend, pend_b;
    srps_pkg::srps_cst_e c_state;
    srps_pkg::srps_dst_e d_state;
    int n_mismatch = 0, comparisons = 0;
    // Clock of 4 ns.
    always #2 i_clk = ~i_clk;
    srps_if bus ();
    // A short refresh period keeps the run brief.
    srps_ctrl #(.REF_CYC(1024), .ROWS(16)) u_srps_ctrl (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_open_row(req[0]), .i_close_row(req[1]), .i_read(req[2]), .i_suspend(req[3]),
        .i_pd_req(req[4]), .i_sr_req(req[5]), .i_deep_req(req[6]), .i_init_done(req[7]),
        .o_state(c_state), .o_pend(pend), .o_row_open(row_open), .bus(bus));
    srps_dram #(.ROWS(16), .SR_INT_CYC(40)) u_srps_dram (.i_clk(i_clk), .i_resetn(i_resetn),
        .bus(bus), .o_state(d_state), .o_row_ctr(row_ctr), .o_refresh(refresh), .o_buf_en(buf_en),
        .o_burst_left(burst_left), .o_data_lost(data_lost));
    srps_monitor u_mon (.i_clk(i_clk), .i_resetn(i_resetn), .cke(bus.cke), .cs_n(bus.cs_n),
        .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n));
    // A second controller in burst mode owes every row at the start of each period.
    srps_if bus_b ();
    srps_ctrl #(.REF_CYC(1024), .ROWS(16), .REF_BURST(1'b1)) u_srps_ctrl_b (.i_clk(i_clk),
        .i_resetn(i_resetn), .i_open_row(1'b0), .i_close_row(1'b0), .i_read(1'b0),
        .i_suspend(1'b0), .i_pd_req(1'b0), .i_sr_req(1'b0), .i_deep_req(1'b0),
        .i_init_done(1'b0), .o_state(), .o_pend(pend_b), .o_row_open(), .bus(bus_b));
    srps_monitor u_mon_b (.i_clk(i_clk), .i_resetn(i_resetn), .cke(bus_b.cke),
        .cs_n(bus_b.cs_n), .ras_n(bus_b.ras_n), .cas_n(bus_b.cas_n), .we_n(bus_b.we_n));
    // Compare one value and tally it.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // Bounded wait for a status value; a pulse is caught since each edge is sampled.
    task automatic wait_for(input string what, input int sel, input logic [15:0] exp);
        logic [15:0] cur;
        // Step off the launching edge so outputs are read settled.
        #1;
        for (int k = 0; k < 600; k++) begin
            cur = sel == 0 ? 16'(d_state) : sel == 1 ? 16'(row_open) : 16'(refresh);
            if (cur === exp) break;
            @(posedge i_clk) #1;
        end
        chk(what, exp, cur);
    endtask : wait_for
    // Report the tallies and stop.
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Watchdog well beyond the longest sequence.
    initial begin
        #60000;
        n_mismatch++;
        wrap_up();
    end
    // Request each state in turn and check what the memory end reports.
    initial begin
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        wait_for("refresh", 2, 16'h1);
        chk("owed burst", 16'h000f, 16'(pend_b));
        @(posedge i_clk) req <= 8'h10;
        wait_for("st", 0, srps_pkg::DS_PPD);
        chk("buffers", 16'h0, 16'(buf_en));
        @(posedge i_clk) req <= 8'h01;
        wait_for("st", 0, srps_pkg::DS_RUN);
        wait_for("row open", 1, 16'h1);
        @(posedge i_clk) req <= 8'h10;
        wait_for("st", 0, srps_pkg::DS_APD);
        @(posedge i_clk) req <= 8'h0c;
        wait_for("st", 0, srps_pkg::DS_SUSP);
        held = burst_left;
        @(posedge i_clk) req <= 8'h08;
        @(posedge i_clk) #1;
        chk("burst beats", 16'(held), 16'(burst_left));
        @(posedge i_clk) req <= 8'h02;
        wait_for("row open", 1, 16'h0);
        @(posedge i_clk) req <= 8'h40;
        wait_for("st", 0, srps_pkg::DS_DEEP);
        @(posedge i_clk) req <= 8'h00;
        wait_for("st", 0, srps_pkg::DS_UNINIT);
        chk("data lost", 16'h1, 16'(data_lost));
        chk("ctrl st", 16'(srps_pkg::CS_INIT), 16'(c_state));
        @(posedge i_clk) req <= 8'h80;
        @(posedge i_clk) req <= 8'h20;
        wait_for("st", 0, srps_pkg::DS_SELF);
        chk("buffers", 16'h0, 16'(buf_en));
        held = 8'(row_ctr);
        wait_for("refresh", 2, 16'h1);
        chk("row counter", 16'(4'(held + 8'h01)), 16'(row_ctr));
        @(posedge i_clk) req <= 8'h00;
        wait_for("st", 0, srps_pkg::DS_RUN);
        // Keep a row open until the next refresh falls due; it must be closed first.
        @(posedge i_clk) req <= 8'h01;
        wait_for("row open", 1, 16'h1);
        wait_for("row open", 1, 16'h0);
        wait_for("refresh", 2, 16'h1);
        chk("owed", 16'h0000, 16'(pend));
        wrap_up();
    end
endmodule : test_sdram_refresh_power_states
